// file: hw/symbol_injection_line_state_regs.sv
`timescale 1ns/1ps
`include "symbol_injection_map.svh"
// Behaviour
// - first register holds 5B code, sent unencoded
// - one-shot replaces the pair n pairs after JK
// - periodic replaces every n-th pair
// - continuous replaces every data pair
// - first symbol register at 06h, bits 0-4
// - symbol LSB serialised last
// - upper bits reset zero, no effect
// - second symbol register at 07h, low bits
// - new line state replaces old at once
// - reset forces unknown line state flag
// - 08h read-only, write sets reject flag
// - code 000 active, entered on JK
// - 001 idle, 010 no signal, 011 reserved
// - 100/101/110 after eight halt-quiet/halt/quiet pairs
// - 111 after sixteen noise events
// - unknown keeps last known state shown
module symbol_injection_line_state_regs
    import symbol_injection_pkg::*;
#(
    parameter int PAIR_COUNT_WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire bus_req_type busReq,
    output logic [7:0] busRdata,
    input wire logic txPairValid,
    input wire symbol_pair_type txPairIn,
    input wire logic txPairIsData,
    output symbol_pair_type txPairOut,
    output logic txPairOutValid,
    output logic txSerial,
    input wire logic rxPairValid,
    input wire symbol_pair_type rxPairIn,
    input wire logic noiseEvent,
    input wire logic signalDetect,
    input wire logic loopback,
    output logic writeRejectPulse
);
    logic [7:0] symFirst_q, symFirst_d, symSecond_q, symSecond_d;
    logic [7:0] threshold_q, threshold_d, counter_q, counter_d;
    inject_mode_type mode_q, mode_d;
    logic armed_q, armed_d;
    logic reject_q, reject_d;
    line_state_type ls_q, ls_d;
    logic unknown_q, unknown_d;
    logic [3:0] runCnt_q, runCnt_d;
    symbol_pair_type lastPair_q, lastPair_d;
    logic [4:0] noiseCnt_q, noiseCnt_d;
    symbol_pair_type txOut_q, txOut_d;
    logic txOutValid_q, txOutValid_d;
    logic [9:0] shift_q, shift_d;
    logic [3:0] bitCnt_q, bitCnt_d;
    logic [7:0] rdata_q, rdata_d;

    function automatic logic hit(input bus_req_type r, input logic [5:0] a);
        return r.sel && r.addr == a;
    endfunction

    function automatic logic isPair(input symbol_pair_type p, input logic [4:0] a,
                                    input logic [4:0] b);
        return p.first == a && p.second == b;
    endfunction

    // register file
    always_comb begin
        symFirst_d = symFirst_q;
        symSecond_d = symSecond_q;
        threshold_d = threshold_q;
        mode_d = mode_q;
        reject_d = 1'b0;
        rdata_d = rdata_q;
        if (busReq.sel && busReq.wr) begin
            if (hit(busReq, `ADDR_INJECT_SYMBOL_FIRST))
                symFirst_d = busReq.data;
            if (hit(busReq, `ADDR_INJECT_SYMBOL_SECOND))
                symSecond_d = busReq.data;
            if (hit(busReq, `ADDR_INJECTION_THRESHOLD))
                threshold_d = busReq.data;
            if (hit(busReq, `ADDR_INJECTION_MODE))
                mode_d = inject_mode_type'(busReq.data[1:0]);
            if (hit(busReq, `ADDR_CURRENT_RX_LINE_STATE))
                reject_d = 1'b1;
        end
        if (busReq.sel && !busReq.wr) begin
            if (hit(busReq, `ADDR_INJECT_SYMBOL_FIRST))
                rdata_d = symFirst_q;
            else if (hit(busReq, `ADDR_INJECT_SYMBOL_SECOND))
                rdata_d = symSecond_q;
            else if (hit(busReq, `ADDR_CURRENT_RX_LINE_STATE))
                rdata_d = {4'h0, unknown_q, ls_q};
            else if (hit(busReq, `ADDR_INJECTION_THRESHOLD))
                rdata_d = threshold_q;
            else if (hit(busReq, `ADDR_INJECTION_MODE))
                rdata_d = {6'h00, mode_q};
            else
                rdata_d = 8'h00;
        end
        // one-shot returns to normal once done; a new mode write wins
        if (mode_q == INJ_ONE_SHOT && txPairValid
            && !(busReq.wr && hit(busReq, `ADDR_INJECTION_THRESHOLD))
            && !(busReq.wr && hit(busReq, `ADDR_INJECTION_MODE))
            && (isPair(txPairIn, `SYM_J, `SYM_K) ? threshold_q == 8'h00
                                                 : armed_q && counter_q == 8'h00))
            mode_d = INJ_NONE;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            symFirst_q <= `INJECT_SYMBOL_RESET;
            symSecond_q <= `INJECT_SYMBOL_RESET;
            threshold_q <= `THRESHOLD_RESET;
            mode_q <= INJ_NONE;
            reject_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            symFirst_q <= symFirst_d;
            symSecond_q <= symSecond_d;
            threshold_q <= threshold_d;
            mode_q <= mode_d;
            reject_q <= reject_d;
            rdata_q <= rdata_d;
        end
    end

    // injection counter and pair replacement
    always_comb begin
        symbol_pair_type inj;
        logic doInject;
        logic isJk;
        inj = '{first: symFirst_q[`SYMBOL_MSB:`SYMBOL_LSB],
                second: symSecond_q[`SYMBOL_MSB:`SYMBOL_LSB]};
        isJk = isPair(txPairIn, `SYM_J, `SYM_K);
        doInject = 1'b0;
        counter_d = counter_q;
        armed_d = armed_q;
        if (hit(busReq, `ADDR_INJECTION_THRESHOLD) && busReq.wr) begin
            counter_d = busReq.data;
        end else if (txPairValid) begin
            case (mode_q)
                INJ_ONE_SHOT: begin
                    if (isJk && threshold_q == 8'h00) begin
                        doInject = 1'b1;
                        armed_d = 1'b0;
                    end else if (isJk) begin
                        armed_d = 1'b1;
                        counter_d = threshold_q - 8'h01;
                    end else if (armed_q && counter_q == 8'h00) begin
                        doInject = 1'b1;
                        armed_d = 1'b0;
                    end else if (armed_q) begin
                        counter_d = counter_q - 8'h01;
                    end
                end
                INJ_PERIODIC: begin
                    if (threshold_q == 8'h00) begin
                        doInject = txPairIsData;
                    end else if (counter_q <= 8'h01) begin
                        doInject = 1'b1;
                        counter_d = threshold_q;
                    end else begin
                        counter_d = counter_q - 8'h01;
                    end
                end
                INJ_CONTINUOUS: doInject = txPairIsData;
                INJ_NONE: armed_d = 1'b0;
                default: armed_d = 1'b0;
            endcase
        end
        txOut_d = txOut_q;
        txOutValid_d = txPairValid;
        if (txPairValid)
            txOut_d = doInject ? inj : txPairIn;
    end

    // serialiser: msb of first symbol first, lsb of second last
    always_comb begin
        shift_d = shift_q;
        bitCnt_d = bitCnt_q;
        if (txOutValid_q) begin
            shift_d = {txOut_q.first, txOut_q.second};
            bitCnt_d = 4'h9;
        end else if (bitCnt_q != 4'h0) begin
            shift_d = {shift_q[8:0], 1'b0};
            bitCnt_d = bitCnt_q - 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            counter_q <= 8'h00;
            armed_q <= 1'b0;
            txOut_q <= '0;
            txOutValid_q <= 1'b0;
            shift_q <= '0;
            bitCnt_q <= 4'h0;
        end else begin
            counter_q <= counter_d;
            armed_q <= armed_d;
            txOut_q <= txOut_d;
            txOutValid_q <= txOutValid_d;
            shift_q <= shift_d;
            bitCnt_q <= bitCnt_d;
        end
    end

    // line-state detector
    always_comb begin
        logic sameRun;
        sameRun = rxPairIn == lastPair_q;
        ls_d = ls_q;
        unknown_d = unknown_q;
        runCnt_d = runCnt_q;
        lastPair_d = lastPair_q;
        noiseCnt_d = noiseCnt_q;
        if (!signalDetect && !loopback) begin
            ls_d = NO_SIGNAL_LS;
            unknown_d = 1'b0;
            runCnt_d = 4'h0;
            noiseCnt_d = 5'h00;
        end else begin
            if (noiseEvent)
                noiseCnt_d = noiseCnt_q + 5'h01;
            // restart the count on entry so noise does not pin the state
            if (noiseCnt_d == `NOISE_EVENT_COUNT) begin
                ls_d = NOISE_LS;
                unknown_d = 1'b0;
                noiseCnt_d = 5'h00;
            end
            if (rxPairValid) begin
                lastPair_d = rxPairIn;
                runCnt_d = (sameRun && runCnt_q != 4'hF) ? runCnt_q + 4'h1 : 4'h1;
                if (isPair(rxPairIn, `SYM_J, `SYM_K)) begin
                    ls_d = ACTIVE_LS;
                    unknown_d = 1'b0;
                    noiseCnt_d = 5'h00;
                end else if (isPair(rxPairIn, `SYM_IDLE, `SYM_IDLE)
                             && runCnt_d >= `IDLE_PAIR_COUNT) begin
                    ls_d = IDLE_LS;
                    unknown_d = 1'b0;
                    noiseCnt_d = 5'h00;
                end else if (isPair(rxPairIn, `SYM_HALT, `SYM_QUIET)
                             && runCnt_d >= `HALT_PAIR_COUNT) begin
                    ls_d = MASTER_LS;
                    unknown_d = 1'b0;
                end else if (isPair(rxPairIn, `SYM_HALT, `SYM_HALT)
                             && runCnt_d >= `HALT_PAIR_COUNT) begin
                    ls_d = HALT_LS;
                    unknown_d = 1'b0;
                end else if (isPair(rxPairIn, `SYM_QUIET, `SYM_QUIET)
                             && runCnt_d >= `HALT_PAIR_COUNT) begin
                    ls_d = QUIET_LS;
                    unknown_d = 1'b0;
                end else if (!(ls_q == ACTIVE_LS && !unknown_q) && !sameRun) begin
                    unknown_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ls_q <= ACTIVE_LS;
            unknown_q <= 1'b1;
            runCnt_q <= 4'h0;
            lastPair_q <= '0;
            noiseCnt_q <= 5'h00;
        end else begin
            ls_q <= ls_d;
            unknown_q <= unknown_d;
            runCnt_q <= runCnt_d;
            lastPair_q <= lastPair_d;
            noiseCnt_q <= noiseCnt_d;
        end
    end

    assign busRdata = rdata_q;
    assign txPairOut = txOut_q;
    assign txPairOutValid = txOutValid_q;
    assign txSerial = shift_q[9];
    assign writeRejectPulse = reject_q;
endmodule

// file: hw/symbol_injection_map.svh
`ifndef SYMBOL_INJECTION_MAP_SVH
`define SYMBOL_INJECTION_MAP_SVH
`define ADDR_INJECT_SYMBOL_FIRST 6'h06
`define ADDR_INJECT_SYMBOL_SECOND 6'h07
`define ADDR_CURRENT_RX_LINE_STATE 6'h08
`define ADDR_INJECTION_THRESHOLD 6'h05
`define ADDR_INJECTION_MODE 6'h0A
`define ADDR_INTERRUPT_CONDITION 6'h02
`define SYMBOL_LSB 0
`define SYMBOL_MSB 4
`define LSU_BIT 3
`define WRITE_REJECT_BIT 0
`define INJECT_SYMBOL_RESET 8'h00
`define THRESHOLD_RESET 8'h00
`define IDLE_PAIR_COUNT 4'h2
`define HALT_PAIR_COUNT 4'h8
`define NOISE_EVENT_COUNT 5'h10
`define SYM_J 5'h18
`define SYM_K 5'h11
`define SYM_IDLE 5'h1F
`define SYM_HALT 5'h04
`define SYM_QUIET 5'h00
`endif

// file: hw/symbol_injection_pkg.sv
package symbol_injection_pkg;
    typedef enum logic [2:0] {
        ACTIVE_LS = 3'h0,
        IDLE_LS = 3'h1,
        NO_SIGNAL_LS = 3'h2,
        RESERVED_LS = 3'h3,
        MASTER_LS = 3'h4,
        HALT_LS = 3'h5,
        QUIET_LS = 3'h6,
        NOISE_LS = 3'h7
    } line_state_type;
    typedef enum logic [1:0] {
        INJ_NONE = 2'h0,
        INJ_ONE_SHOT = 2'h1,
        INJ_PERIODIC = 2'h2,
        INJ_CONTINUOUS = 2'h3
    } inject_mode_type;
    typedef struct packed {
        logic [4:0] first;
        logic [4:0] second;
    } symbol_pair_type;
    typedef struct packed {
        logic sel;
        logic wr;
        logic [5:0] addr;
        logic [7:0] data;
    } bus_req_type;
endpackage

// file: tb/symbol_injection_props.sv
`timescale 1ns/1ps
module symbol_injection_props
    import symbol_injection_pkg::*;
#(
    parameter int PAIR_COUNT_WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire bus_req_type busReq,
    input wire logic [7:0] busRdata,
    input wire logic txPairValid,
    input wire symbol_pair_type txPairIn,
    input wire logic txPairIsData,
    input wire symbol_pair_type txPairOut,
    input wire logic txPairOutValid,
    input wire logic txSerial,
    input wire logic rxPairValid,
    input wire symbol_pair_type rxPairIn,
    input wire logic noiseEvent,
    input wire logic signalDetect,
    input wire logic loopback,
    input wire logic writeRejectPulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wr08;
        busReq.sel && busReq.wr && busReq.addr == 6'h08;
    endsequence
    sequence s_rd;
        busReq.sel && !busReq.wr;
    endsequence
    property p_rej;
        s_wr08 |=> writeRejectPulse;
    endproperty
    a_rej: assert property (p_rej) else $error("write to 08h not refused");
    property p_norej;
        writeRejectPulse |-> $past(busReq.sel && busReq.wr && busReq.addr == 6'h08);
    endproperty
    a_norej: assert property (p_norej) else $error("stray reject pulse");
    property p_outv;
        txPairValid |=> txPairOutValid;
    endproperty
    a_outv: assert property (p_outv) else $error("pair not passed on");
    property p_nooutv;
        !txPairValid |=> !txPairOutValid;
    endproperty
    a_nooutv: assert property (p_nooutv) else $error("pair out without pair in");
    property p_first;
        txPairOutValid |=> txSerial == $past(txPairOut.first[4]);
    endproperty
    a_first: assert property (p_first) else $error("first symbol not sent first");
    property p_last;
        txPairOutValid |-> ##10 txSerial == $past(txPairOut.second[0], 10);
    endproperty
    a_last: assert property (p_last) else $error("symbol lsb not sent last");
    property p_hold;
        !(busReq.sel && !busReq.wr) |=> $stable(busRdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap;
        s_rd ##0 busReq.addr > 6'h0A |=> busRdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule

// file: tb/mgmt_host_model.sv
`timescale 1ns/1ps
module mgmt_host_model
    import symbol_injection_pkg::*;
(
    input wire logic clk,
    output bus_req_type busReq,
    input wire logic [7:0] busRdata
);
    initial busReq = '0;
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        busReq = '{1'b1, 1'b1, a, d};
        @(negedge clk);
        busReq = '0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk);
        busReq = '{1'b1, 1'b0, a, 8'h00};
        @(negedge clk);
        busReq = '0;
        d = busRdata;
    endtask
endmodule

// file: tb/symbol_injection_line_state_regs_bench.sv
`timescale 1ns/1ps
module symbol_injection_line_state_regs_bench;
    import symbol_injection_pkg::*;
    logic clk, rst, txPairValid, txPairIsData, rxPairValid, noiseEvent, signalDetect, loopback;
    logic txPairOutValid, txSerial, writeRejectPulse;
    logic [7:0] busRdata;
    symbol_pair_type txPairIn, rxPairIn, txPairOut;
    bus_req_type busReq;
    int n_errors = 0;
    int n_compared = 0;
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    mgmt_host_model i_host (
        .clk(clk),
        .busReq(busReq),
        .busRdata(busRdata)
    );
    symbol_injection_line_state_regs #(.PAIR_COUNT_WIDTH(4)) i_dut (
        .clk(clk),
        .rst(rst),
        .busReq(busReq),
        .busRdata(busRdata),
        .txPairValid(txPairValid),
        .txPairIn(txPairIn),
        .txPairIsData(txPairIsData),
        .txPairOut(txPairOut),
        .txPairOutValid(txPairOutValid),
        .txSerial(txSerial),
        .rxPairValid(rxPairValid),
        .rxPairIn(rxPairIn),
        .noiseEvent(noiseEvent),
        .signalDetect(signalDetect),
        .loopback(loopback),
        .writeRejectPulse(writeRejectPulse)
    );
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        chk({2'b00, d}, {2'b00, e});
    endtask
    task automatic rxp(input logic [9:0] p, input int n);
        @(negedge clk);
        rxPairValid = 1;
        rxPairIn = p;
        repeat (n) @(negedge clk);
        rxPairValid = 0;
    endtask
    task automatic txp(input logic [9:0] p, input logic dat, input logic [9:0] e);
        logic [9:0] ser;
        @(negedge clk);
        txPairValid = 1;
        txPairIn = p;
        txPairIsData = dat;
        @(negedge clk);
        txPairValid = 0;
        chk(txPairOut, e);
        // serialiser loads one cycle after the pair is registered
        @(negedge clk);
        for (int i = 9; i >= 0; i--) begin
            ser[i] = txSerial;
            @(negedge clk);
        end
        chk(ser, e);
    endtask
    task automatic t_regs;
        rdchk(6'h08, 8'h08);
        rdchk(6'h06, 8'h00);
        i_host.wr(6'h06, 8'hF5);
        i_host.wr(6'h07, 8'hEA);
        rdchk(6'h06, 8'hF5);
        rdchk(6'h07, 8'hEA);
        rdchk(6'h3F, 8'h00);
        i_host.wr(6'h08, 8'hFF);
        chk({9'h000, writeRejectPulse}, 10'h001);
        rdchk(6'h08, 8'h08);
    endtask
    task automatic t_states;
        rxp(10'h311, 1);
        rdchk(6'h08, 8'h00);
        rxp(10'h3FF, 2);
        rdchk(6'h08, 8'h01);
        rxp(10'h080, 8);
        rdchk(6'h08, 8'h04);
        rxp(10'h084, 8);
        rdchk(6'h08, 8'h05);
        rxp(10'h000, 8);
        rdchk(6'h08, 8'h06);
        rxp(10'h3C9, 1);
        rdchk(6'h08, 8'h0E);
        @(negedge clk);
        noiseEvent = 1;
        repeat (16) @(negedge clk);
        noiseEvent = 0;
        rdchk(6'h08, 8'h07);
        loopback = 1;
        signalDetect = 0;
        rdchk(6'h08, 8'h07);
        loopback = 0;
        rdchk(6'h08, 8'h02);
    endtask
    task automatic t_inject;
        i_host.wr(6'h06, 8'hED);
        i_host.wr(6'h07, 8'h13);
        i_host.wr(6'h0A, 8'h03);
        txp(10'h2A5, 1, 10'h1B3);
        i_host.wr(6'h0A, 8'h00);
        txp(10'h2C7, 1, 10'h2C7);
        i_host.wr(6'h05, 8'h00);
        i_host.wr(6'h0A, 8'h02);
        txp(10'h2C7, 1, 10'h1B3);
        i_host.wr(6'h0A, 8'h01);
        txp(10'h311, 0, 10'h1B3);
        rdchk(6'h0A, 8'h00);
        i_host.wr(6'h05, 8'h02);
        i_host.wr(6'h0A, 8'h02);
        txp(10'h2C7, 1, 10'h2C7);
        txp(10'h2C7, 1, 10'h1B3);
        i_host.wr(6'h05, 8'h01);
        i_host.wr(6'h0A, 8'h01);
        txp(10'h311, 0, 10'h311);
        txp(10'h2C7, 1, 10'h1B3);
        rdchk(6'h0A, 8'h00);
    endtask
    task automatic t_reset;
        signalDetect = 1;
        @(negedge clk);
        rst = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        rdchk(6'h08, 8'h08);
        rdchk(6'h06, 8'h00);
        rdchk(6'h07, 8'h00);
    endtask
    initial begin
        {rst, txPairValid, txPairIsData, rxPairValid, noiseEvent, loopback} = 6'h20;
        signalDetect = 1;
        txPairIn = '0;
        rxPairIn = '0;
        repeat (12) @(negedge clk);
        rst = 0;
        t_regs();
        t_states();
        t_inject();
        t_reset();
        conclude();
    end
    initial begin
        #20000;
        n_errors++;
        conclude();
    end
endmodule
bind symbol_injection_line_state_regs symbol_injection_props #(
    .PAIR_COUNT_WIDTH(PAIR_COUNT_WIDTH)
) i_props (
    .clk(clk),
    .rst(rst),
    .busReq(busReq),
    .busRdata(busRdata),
    .txPairValid(txPairValid),
    .txPairIn(txPairIn),
    .txPairIsData(txPairIsData),
    .txPairOut(txPairOut),
    .txPairOutValid(txPairOutValid),
    .txSerial(txSerial),
    .rxPairValid(rxPairValid),
    .rxPairIn(rxPairIn),
    .noiseEvent(noiseEvent),
    .signalDetect(signalDetect),
    .loopback(loopback),
    .writeRejectPulse(writeRejectPulse)
);
